// ===== logic/lsd_regs.svh
// Register map, field positions and timing figures of the segment display controller.
// Assumes a 125 MHz bus clock and a 32 kHz low-speed oscillator reference.
`ifndef LSD_REGS_SVH
`define LSD_REGS_SVH

`define LSD_ADDR_W 8
`define LSD_OFS_CTRL 8'h00
`define LSD_OFS_PWR 8'h04
`define LSD_OFS_STAT 8'h08
`define LSD_OFS_MEM_LO 8'h40
`define LSD_OFS_MEM_HI 8'hBC

`define LSD_CTRL_RESET 8'h00
`define LSD_PWR_RESET 8'h00
`define LSD_CTRL_MASK 8'h87
`define LSD_PWR_MASK 8'h1B
`define LSD_CTRL_EN 0
`define LSD_CTRL_IS_LO 1
`define LSD_CTRL_IS_HI 2
`define LSD_CTRL_TYPE 7
`define LSD_PWR_CPV_LO 0
`define LSD_PWR_CPV_HI 1
`define LSD_PWR_SRC 3
`define LSD_PWR_DUTY 4

`define LSD_SEGS 32
`define LSD_SEGS_6 30
`define LSD_COMS 6
`define LSD_COMS_4 4
`define LSD_LVL_VSS 2'h0
`define LSD_LVL_VC 2'h1
`define LSD_LVL_VB 2'h2
`define LSD_LVL_VA 2'h3

`define LSD_RESP_OKAY 2'h0
`define LSD_RESP_DECERR 2'h3

`define LSD_CLK_HZ 125000000
`define LSD_LOW_SPEED_RC_OSCILLATOR_HZ 32000
`define LSD_DISP_DIV 8
`define LSD_TRSTD_NS 1000
`define LSD_TSST_NS 2000

`endif

// ===== logic/lsd_pkg.sv
// Types shared by the segment display controller modules.
// Assumes lsd_regs.svh supplies the numeric constants.
`default_nettype none
package lsd_pkg;
    typedef enum logic [4:0] {
        LSD_RG_CTRL = 5'h01,
        LSD_RG_PWR = 5'h02,
        LSD_RG_STAT = 5'h04,
        LSD_RG_MEM = 5'h08,
        LSD_RG_NONE = 5'h10
    } lsd_region_t;
    typedef logic [1:0] lsd_level_t;
endpackage
`default_nettype wire

// ===== logic/lsd_seq_if.sv
// Carrier between the display controller and its frame sequencer.
// Assumes both ends run on the same bus clock.
`timescale 1ns/1ps
`default_nettype none
interface lsd_seq_if;
    logic run;
    logic type_b;
    logic duty6;
    logic [2:0] slot;
    logic pol;
    modport ctrl (output run, output type_b, output duty6, input slot, input pol);
    modport seq (input run, input type_b, input duty6, output slot, output pol);
endinterface
`default_nettype wire

// ===== logic/lsd_frame_seq.sv
// Frame sequencer: display clock divider, common slot counter and drive polarity.
// Assumes run is low whenever the driver is in its internal reset.
`timescale 1ns/1ps
`default_nettype none
`include "lsd_regs.svh"
module lsd_frame_seq
    import lsd_pkg::*;
#(
    parameter int unsigned TICK_CYC = 31250
) (
    input wire logic aclk,
    input wire logic aresetn,
    lsd_seq_if.seq sq
);
    logic [15:0] div_r;
    logic half_r;
    logic frame_pol_r;
    logic [2:0] slot_r;
    logic tick;
    logic slot_last;

    // R21: display clock tick
    assign tick = div_r == 16'(TICK_CYC - 1);
    // R17: slots per frame
    assign slot_last = slot_r == (sq.duty6 ? 3'(`LSD_COMS - 1) : 3'(`LSD_COMS_4 - 1));

    always_ff @(posedge aclk) begin
        if (!aresetn || !sq.run || tick) begin
            div_r <= 16'h0000;
        end else begin
            div_r <= div_r + 16'h0001;
        end
    end

    // R25: polarity scheme per type
    always_ff @(posedge aclk) begin
        if (!aresetn || !sq.run) begin
            half_r <= 1'b0;
            frame_pol_r <= 1'b0;
            slot_r <= 3'h0;
        end else if (tick) begin
            half_r <= sq.type_b ? 1'b0 : !half_r;
            // R19: type B steps a slot per tick
            if (sq.type_b || half_r) begin
                slot_r <= slot_last ? 3'h0 : slot_r + 3'h1;
                if (slot_last && sq.type_b) begin
                    frame_pol_r <= !frame_pol_r;
                end
            end
        end
    end

    assign sq.slot = slot_r;
    assign sq.pol = sq.type_b ? frame_pol_r : half_r;
endmodule
`default_nettype wire

// ===== logic/lsd_display_ctrl.sv
// Segment display controller: AXI4-Lite registers, display memory, reset control and drive levels.
// Assumes sleep and reset requests come from logic on aclk; the analog bias network sits outside.
//
// Functional notes
// R01: Enable bit works in FAST, SLOW, IDLE; SLEEP always disables display.
// R02: Bit 7 of display control picks waveform type A or B.
// R03: Bits 2 to 1 pick bias current 25, 50, 100 or 200 uA.
// R04: Bit 4 of power/duty register picks 1/4 or 1/6 duty.
// R05: Quarter duty drives commons 0 to 3 only; sixth duty drives all six.
// R06: Bit 3 picks external supply pin or internal charge pump.
// R07: Bits 1 to 0 pick pump level 3.3, 3.0, 2.7 or 4.5 V.
// R08: Pump runs only when enable and power-source bits are both set.
// R09: Unimplemented register bits read as zero.
// R10: Driver reset is enable clear OR sleep.
// R11: Driver reset without MCU reset forces all outputs low.
// R12: MCU reset floats all common and segment outputs.
// R13: Watchdog time-out in IDLE or SLEEP is not an MCU reset.
// R14: Float extends over reset delay plus start-up time.
// R15: Arrangement is 32x4 or 30x6 with fixed one-third bias.
// R16: Drive uses ground, one third, two thirds and full level.
// R17: Frame has one slot per active common line.
// R18: Waveforms keep net pixel DC at zero.
// R19: Type B runs at lower frequency than type A.
// R20: Bias DC path is off while display is disabled.
// R21: Display clock is low-speed oscillator divided by eight.
// R22: Display memory is read continuously onto the outputs.
// R23: Quarter duty reads unused common memory bits as zero.
// R24: Enable bit is clear after power-on.
// R25: Type A flips polarity inside each slot, type B every frame.
// R26: On pixels see full swing, off pixels one third.
// R27: All implemented control bits reset to zero.
`timescale 1ns/1ps
`default_nettype none
`include "lsd_regs.svh"
module lsd_display_ctrl
    import lsd_pkg::*;
#(
    parameter int unsigned TICK_CYC = `LSD_CLK_HZ / (`LSD_LOW_SPEED_RC_OSCILLATOR_HZ / `LSD_DISP_DIV),
    parameter int unsigned TRSTD_NS = `LSD_TRSTD_NS,
    parameter int unsigned TSST_NS = `LSD_TSST_NS
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic sleep_mode,
    input wire logic mcu_reset,
    input wire logic wdt_lowpower_reset,
    output logic [11:0] com_level,
    output logic [5:0] com_oe,
    output logic [63:0] seg_level,
    output logic [31:0] seg_oe,
    output logic [1:0] bias_current_sel,
    output logic bias_path_on,
    output logic supply_from_pump,
    output logic pump_enable,
    output logic [1:0] pump_voltage_sel,
    output logic display_active
);
    localparam int unsigned CLK_MHZ = `LSD_CLK_HZ / 1000000;
    localparam int unsigned HOLD_CYC = ((TRSTD_NS + TSST_NS) * CLK_MHZ + 999) / 1000;
    localparam logic [15:0] HOLD_CYC_W = 16'(HOLD_CYC < 1 ? 1 : HOLD_CYC);

    function automatic lsd_region_t lsd_decode(input logic [7:0] a);
        if (a[1:0] != 2'h0) begin
            return LSD_RG_NONE;
        end else if (a == `LSD_OFS_CTRL) begin
            return LSD_RG_CTRL;
        end else if (a == `LSD_OFS_PWR) begin
            return LSD_RG_PWR;
        end else if (a == `LSD_OFS_STAT) begin
            return LSD_RG_STAT;
        end else if (a >= `LSD_OFS_MEM_LO && a <= `LSD_OFS_MEM_HI) begin
            return LSD_RG_MEM;
        end
        return LSD_RG_NONE;
    endfunction

    function automatic logic [4:0] lsd_mem_idx(input logic [7:0] a);
        logic [7:0] d;
        d = a - `LSD_OFS_MEM_LO;
        return d[6:2];
    endfunction

    // R16: four-level one-third bias drive
    function automatic lsd_level_t lsd_com_lvl(input logic sel, input logic pol);
        if (sel) begin
            return pol ? `LSD_LVL_VSS : `LSD_LVL_VA;
        end
        return pol ? `LSD_LVL_VB : `LSD_LVL_VC;
    endfunction

    // R26: segment level against the selected common
    function automatic lsd_level_t lsd_seg_lvl(input logic on, input logic pol);
        if (on) begin
            return pol ? `LSD_LVL_VA : `LSD_LVL_VSS;
        end
        return pol ? `LSD_LVL_VC : `LSD_LVL_VB;
    endfunction

    logic [7:0] ctrl_r;
    logic [7:0] pwr_r;
    logic [5:0] mem_r [`LSD_SEGS];
    logic aw_held_r;
    logic [7:0] aw_addr_r;
    logic w_held_r;
    logic [31:0] w_data_r;
    logic w_strb_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;
    logic [15:0] hold_cnt_r;
    logic float_r;
    logic [11:0] com_level_r;
    logic [5:0] com_oe_r;
    logic [63:0] seg_level_r;
    logic [31:0] seg_oe_r;
    logic aw_take;
    logic w_take;
    logic wr_go;
    logic [7:0] wr_addr;
    logic [31:0] wr_data;
    logic wr_lane0;
    lsd_region_t wr_rg;
    lsd_region_t rd_rg;
    logic [31:0] rd_word;
    logic mcu_req;
    logic drv_on;
    logic duty6;
    logic [5:0] mem_rd;

    lsd_seq_if sq_if ();

    lsd_frame_seq #(
        .TICK_CYC(TICK_CYC)
    ) u_seq (
        .aclk(aclk),
        .aresetn(aresetn),
        .sq(sq_if.seq)
    );

    // R04: duty select bit
    assign duty6 = pwr_r[`LSD_PWR_DUTY];
    // R01: sleep overrides the enable bit
    // R10: internal reset is enable clear OR sleep
    assign drv_on = ctrl_r[`LSD_CTRL_EN] && !sleep_mode;
    // R13: watchdog time-out in low power is excluded
    assign mcu_req = mcu_reset && !wdt_lowpower_reset;

    assign sq_if.run = drv_on && !float_r;
    // R02: waveform type select
    assign sq_if.type_b = ctrl_r[`LSD_CTRL_TYPE];
    assign sq_if.duty6 = duty6;

    assign aw_take = s_axi_awvalid && s_axi_awready;
    assign w_take = s_axi_wvalid && s_axi_wready;
    assign s_axi_awready = !aw_held_r && !bvalid_r;
    assign s_axi_wready = !w_held_r && !bvalid_r;
    assign wr_addr = aw_held_r ? aw_addr_r : s_axi_awaddr;
    assign wr_data = w_held_r ? w_data_r : s_axi_wdata;
    assign wr_lane0 = w_held_r ? w_strb_r : s_axi_wstrb[0];
    assign wr_go = (aw_held_r || aw_take) && (w_held_r || w_take);
    assign wr_rg = lsd_decode(wr_addr);
    assign rd_rg = lsd_decode(s_axi_araddr);

    always_ff @(posedge aclk) begin
        if (!aresetn || wr_go) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
        end else begin
            aw_held_r <= aw_held_r || aw_take;
            w_held_r <= w_held_r || w_take;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_addr_r <= 8'h00;
            w_data_r <= 32'h0000_0000;
            w_strb_r <= 1'b0;
        end else begin
            if (aw_take) begin
                aw_addr_r <= s_axi_awaddr;
            end
            if (w_take) begin
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb[0];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_r <= 1'b0;
            bresp_r <= `LSD_RESP_OKAY;
        end else if (wr_go) begin
            bvalid_r <= 1'b1;
            bresp_r <= (wr_rg == LSD_RG_NONE) ? `LSD_RESP_DECERR : `LSD_RESP_OKAY;
        end else if (s_axi_bready) begin
            bvalid_r <= 1'b0;
        end
    end

    // R24: enable bit clear after reset
    // R27: all implemented bits reset to zero
    // R09: unimplemented bits never stored
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_r <= `LSD_CTRL_RESET;
            pwr_r <= `LSD_PWR_RESET;
        end else if (wr_go && wr_lane0) begin
            if (wr_rg == LSD_RG_CTRL) begin
                ctrl_r <= wr_data[7:0] & `LSD_CTRL_MASK;
            end
            if (wr_rg == LSD_RG_PWR) begin
                pwr_r <= wr_data[7:0] & `LSD_PWR_MASK;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (wr_go && wr_lane0 && wr_rg == LSD_RG_MEM) begin
            mem_r[lsd_mem_idx(wr_addr)] <= wr_data[5:0];
        end
    end

    // R23: unused common bits read as zero
    assign mem_rd = mem_r[lsd_mem_idx(s_axi_araddr)] & (duty6 ? 6'h3F : 6'h0F);

    always_comb begin
        rd_word = 32'h0000_0000;
        unique case (rd_rg)
            LSD_RG_CTRL: rd_word[7:0] = ctrl_r;
            LSD_RG_PWR: rd_word[7:0] = pwr_r;
            LSD_RG_STAT: rd_word = {26'h0, sq_if.slot, float_r, pump_enable, display_active};
            LSD_RG_MEM: rd_word[5:0] = mem_rd;
            LSD_RG_NONE: rd_word = 32'h0000_0000;
        endcase
    end

    assign s_axi_arready = !rvalid_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= `LSD_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_r <= 1'b1;
            rdata_r <= rd_word;
            rresp_r <= (rd_rg == LSD_RG_NONE) ? `LSD_RESP_DECERR : `LSD_RESP_OKAY;
        end else if (s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    // R14: float extends after the reset request ends
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hold_cnt_r <= 16'h0000;
        end else if (mcu_req) begin
            hold_cnt_r <= HOLD_CYC_W;
        end else if (hold_cnt_r != 16'h0000) begin
            hold_cnt_r <= hold_cnt_r - 16'h0001;
        end
    end

    // R12: outputs float during an MCU reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            float_r <= 1'b0;
        end else begin
            float_r <= mcu_req || hold_cnt_r > 16'h0001;
        end
    end

    // R22: memory is scanned continuously
    // R18: balanced levels per polarity
    always_ff @(posedge aclk) begin
        if (!aresetn || !drv_on || float_r) begin
            // R11: internal reset drives everything low
            com_level_r <= 12'h000;
            seg_level_r <= 64'h0;
        end else begin
            for (int c = 0; c < `LSD_COMS; c++) begin
                com_level_r[2*c +: 2] <= lsd_com_lvl(sq_if.slot == 3'(c), sq_if.pol);
            end
            for (int s = 0; s < `LSD_SEGS; s++) begin
                seg_level_r[2*s +: 2] <= lsd_seg_lvl(mem_r[s][sq_if.slot], sq_if.pol);
            end
        end
    end

    // R05: quarter duty releases commons 4 and 5
    // R15: 32x4 or 30x6 arrangement
    always_ff @(posedge aclk) begin
        if (!aresetn || float_r) begin
            com_oe_r <= 6'h00;
            seg_oe_r <= 32'h0000_0000;
        end else begin
            com_oe_r <= duty6 ? 6'h3F : 6'h0F;
            seg_oe_r <= duty6 ? 32'h3FFF_FFFF : 32'hFFFF_FFFF;
        end
    end

    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;
    assign com_level = com_level_r;
    assign com_oe = com_oe_r;
    assign seg_level = seg_level_r;
    assign seg_oe = seg_oe_r;
    // R03: bias current code
    assign bias_current_sel = {ctrl_r[`LSD_CTRL_IS_HI], ctrl_r[`LSD_CTRL_IS_LO]};
    // R20: DC path off when disabled
    assign bias_path_on = drv_on;
    // R06: supply source select
    assign supply_from_pump = pwr_r[`LSD_PWR_SRC];
    // R08: pump needs enable and source bits
    assign pump_enable = ctrl_r[`LSD_CTRL_EN] && pwr_r[`LSD_PWR_SRC];
    // R07: pump level code
    assign pump_voltage_sel = {pwr_r[`LSD_PWR_CPV_HI], pwr_r[`LSD_PWR_CPV_LO]};
    assign display_active = drv_on && !float_r;

    sleep_blank_a: assert property (@(posedge aclk) disable iff (!aresetn) // R01
        (sleep_mode && !float_r) |=> (com_level == 12'h000 && seg_level == 64'h0))
        else $error("outputs not low during sleep");
    pump_gate_a: assert property (@(posedge aclk) disable iff (!aresetn) // R08
        pump_enable |-> (ctrl_r[`LSD_CTRL_EN] && supply_from_pump))
        else $error("pump on without enable and source");
    mcu_float_a: assert property (@(posedge aclk) disable iff (!aresetn) // R12
        mcu_req |=> ##1 (com_oe == 6'h00 && seg_oe == 32'h0000_0000))
        else $error("outputs driven during reset");
    wdt_exclude_a: assert property (@(posedge aclk) disable iff (!aresetn) // R13
        (wdt_lowpower_reset && !float_r && hold_cnt_r == 16'h0000) |=> ##1 com_oe[0])
        else $error("watchdog reset floated outputs");
    hold_load_a: assert property (@(posedge aclk) disable iff (!aresetn) // R14
        mcu_req |=> (hold_cnt_r == HOLD_CYC_W))
        else $error("hold counter not loaded");
    hold_float_a: assert property (@(posedge aclk) disable iff (!aresetn) // R14
        (hold_cnt_r > 16'h0001) |=> (float_r && com_oe == 6'h00))
        else $error("float ended before hold time");
    quarter_com_a: assert property (@(posedge aclk) disable iff (!aresetn) // R05
        (aresetn && !duty6 && !float_r) ##1 !duty6 |-> (com_oe == 6'h0F))
        else $error("unused commons driven");
    mem_mask_a: assert property (@(posedge aclk) disable iff (!aresetn) // R23
        (s_axi_arvalid && s_axi_arready && rd_rg == LSD_RG_MEM && !duty6) |=> (s_axi_rdata[5:4] == 2'h0))
        else $error("unused memory bits read nonzero");
    reserved_zero_a: assert property (@(posedge aclk) disable iff (!aresetn) // R09
        s_axi_rvalid |-> (s_axi_rdata[31:8] == 24'h0 && (ctrl_r & ~`LSD_CTRL_MASK) == 8'h00))
        else $error("reserved bits nonzero");
    bias_off_a: assert property (@(posedge aclk) disable iff (!aresetn) // R20
        (!ctrl_r[`LSD_CTRL_EN] || sleep_mode) |-> !bias_path_on)
        else $error("bias path on while disabled");
endmodule
`default_nettype wire

// ===== dv/lsd_glass_model.sv
// Passive segment glass seen by the display controller outputs.
// Assumes level codes 0 to 3 are equal steps of one third of the top level.
`timescale 1ns/1ps
`default_nettype none
module lsd_glass_model (
    input wire logic aclk,
    input wire logic clr,
    input wire logic [11:0] com_level,
    input wire logic [5:0] com_oe,
    input wire logic [63:0] seg_level,
    input wire logic [31:0] seg_oe
);
    int dc_sum [32][6];
    int max_diff [32][6];
    int n_chg;
    logic [1:0] com0_prev;

    always @(posedge aclk) begin
        int d;
        for (int s = 0; s < 32; s++) begin
            for (int c = 0; c < 6; c++) begin
                d = int'(com_level[2*c+:2]) - int'(seg_level[2*s+:2]);
                if (clr) begin
                    dc_sum[s][c] = 0;
                    max_diff[s][c] = 0;
                end else if (com_oe[c] && seg_oe[s]) begin
                    dc_sum[s][c] = dc_sum[s][c] + d;
                    if (d < 0) d = -d;
                    if (d > max_diff[s][c]) max_diff[s][c] = d;
                end
            end
        end
        if (clr) n_chg = 0;
        else if (com_level[1:0] != com0_prev) n_chg = n_chg + 1;
        com0_prev = com_level[1:0];
    end
endmodule
`default_nettype wire

// ===== dv/lsd_display_ctrl_tb.sv
// Self-checking bench for the segment display controller.
// Assumes short tick and hold parameters so that whole frames fit in a short run.
`timescale 1ns/1ps
`default_nettype none
`include "lsd_regs.svh"
module lsd_display_ctrl_tb;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, sleep_mode, mcu_reset, wdt_lowpower_reset;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, seg_oe, rd, c, p, d;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, bias_current_sel, pump_voltage_sel, rsp;
    logic [11:0] com_level;
    logic [5:0] com_oe;
    logic [63:0] seg_level;
    logic bias_path_on, supply_from_pump, pump_enable, display_active, clr;
    logic [5:0] mem [32];
    int n_fail, num_checks, per, na;

    lsd_display_ctrl #(.TICK_CYC(8), .TRSTD_NS(16), .TSST_NS(16)) dut (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sleep_mode, .mcu_reset,
        .wdt_lowpower_reset, .com_level, .com_oe, .seg_level, .seg_oe, .bias_current_sel,
        .bias_path_on, .supply_from_pump, .pump_enable, .pump_voltage_sel, .display_active
    );
    lsd_glass_model gl (.aclk, .clr, .com_level, .com_oe, .seg_level, .seg_oe);

    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic end_sim();
        $display("Checks %0d, mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // Write handshakes are judged mid cycle, where ready and valid are settled.
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic ta, tw, hb;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        hb = 1'b0;
        while (!hb) begin
            @(negedge aclk);
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            hb = s_axi_bvalid && s_axi_bready;
            rsp = s_axi_bresp;
            @(posedge aclk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
            if (hb) s_axi_bready <= 1'b0;
        end
    endtask

    task automatic rdr(input logic [7:0] a);
        logic ta, hr;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        hr = 1'b0;
        while (!hr) begin
            @(negedge aclk);
            ta = s_axi_arvalid && s_axi_arready;
            hr = s_axi_rvalid && s_axi_rready;
            rd = s_axi_rdata;
            rsp = s_axi_rresp;
            @(posedge aclk);
            if (ta) s_axi_arvalid <= 1'b0;
            if (hr) s_axi_rready <= 1'b0;
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge aclk);
        @(negedge aclk);
    endtask

    initial begin
        repeat (20000) @(posedge aclk);
        n_fail++;
        end_sim();
    end

    initial begin
        aresetn = 1'b0;
        s_axi_awvalid = 1'b0;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b0;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0;
        s_axi_awaddr = 8'h00;
        s_axi_araddr = 8'h00;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hF;
        sleep_mode = 1'b0;
        mcu_reset = 1'b0;
        wdt_lowpower_reset = 1'b0;
        clr = 1'b0;
        void'($urandom(32'h295C));
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        rdr(`LSD_OFS_CTRL);
        chk("ctrl reset", rd, 32'h0);
        rdr(`LSD_OFS_PWR);
        chk("pwr reset", rd, 32'h0);
        chk("levels after reset", |{com_level, seg_level}, 32'h0);
        for (int i = 0; i < 8; i++) begin
            c = $urandom;
            c[2:0] = {i[1:0], i[2]};
            p = $urandom;
            p[1:0] = i[1:0];
            p[3] = i[0];
            wr(`LSD_OFS_CTRL, c);
            wr(`LSD_OFS_PWR, p);
            rdr(`LSD_OFS_CTRL);
            chk("ctrl read", rd, c & 32'h87);
            rdr(`LSD_OFS_PWR);
            chk("pwr read", rd, p & 32'h1B);
            chk("bias current", bias_current_sel, c[2:1]);
            chk("pump voltage", pump_voltage_sel, p[1:0]);
            chk("supply source", supply_from_pump, p[3]);
            chk("pump enable", pump_enable, c[0] & p[3]);
            chk("bias path", bias_path_on, c[0]);
        end
        rdr(8'hC0);
        chk("unmapped read", {rd[29:0], rsp}, 32'h3);
        wr(8'hC0, 32'hFF);
        chk("unmapped write", rsp, 2'h3);
        for (int s = 0; s < 32; s++) begin
            d = $urandom;
            mem[s] = d[5:0];
            wr(`LSD_OFS_MEM_LO + 8'(4 * s), d);
        end
        wr(`LSD_OFS_PWR, 32'h0);
        rdr(`LSD_OFS_MEM_LO + 8'h14);
        chk("mem quarter duty", rd, 32'(mem[5] & 6'h0F));
        for (int d6 = 0; d6 < 2; d6++) begin
            for (int ty = 0; ty < 2; ty++) begin
                wr(`LSD_OFS_PWR, d6 ? 32'h10 : 32'h0);
                wr(`LSD_OFS_CTRL, ty ? 32'h81 : 32'h01);
                per = (d6 ? 6 : 4) * 16;
                repeat (2 * per) @(posedge aclk);
                clr <= 1'b1;
                @(posedge aclk);
                clr <= 1'b0;
                settle(2 * per);
                chk("com enables", com_oe, d6 ? 6'h3F : 6'h0F);
                chk("seg enables", seg_oe, d6 ? 32'h3FFFFFFF : 32'hFFFFFFFF);
                for (int s = 0; s < (d6 ? 30 : 32); s++) begin
                    for (int k = 0; k < (d6 ? 6 : 4); k++) begin
                        chk("pixel dc", gl.dc_sum[s][k], 32'h0);
                        chk("pixel swing", gl.max_diff[s][k], mem[s][k] ? 32'h3 : 32'h1);
                    end
                end
                if (ty == 0) na = gl.n_chg;
                else chk("type b slower", gl.n_chg < na, 32'h1);
            end
        end
        rdr(`LSD_OFS_MEM_LO + 8'h14);
        chk("mem sixth duty", rd, 32'(mem[5]));
        @(posedge aclk);
        sleep_mode <= 1'b1;
        settle(3);
        chk("sleep active", display_active, 1'b0);
        chk("sleep bias", bias_path_on, 1'b0);
        chk("sleep levels", |{com_level, seg_level}, 32'h0);
        @(posedge aclk);
        sleep_mode <= 1'b0;
        settle(3);
        chk("wake active", display_active, 1'b1);
        rdr(`LSD_OFS_STAT);
        chk("status active", rd[2:0], 32'h1);
        wr(`LSD_OFS_CTRL, 32'h0);
        settle(3);
        chk("disabled levels", |{com_level, seg_level}, 32'h0);
        chk("disabled bias", bias_path_on, 1'b0);
        wr(`LSD_OFS_CTRL, 32'h1);
        @(posedge aclk);
        mcu_reset <= 1'b1;
        settle(4);
        chk("float enables", |{com_oe, seg_oe}, 32'h0);
        @(posedge aclk);
        mcu_reset <= 1'b0;
        settle(4);
        chk("float hold", |com_oe, 32'h0);
        settle(10);
        chk("float end", com_oe, 6'h3F);
        @(posedge aclk);
        mcu_reset <= 1'b1;
        wdt_lowpower_reset <= 1'b1;
        settle(4);
        chk("watchdog no float", com_oe, 6'h3F);
        @(posedge aclk);
        mcu_reset <= 1'b0;
        wdt_lowpower_reset <= 1'b0;
        rdr(`LSD_OFS_CTRL);
        chk("ctrl kept", rd, 32'h1);
        end_sim();
    end
endmodule
`default_nettype wire
